/* include/dsrp_lp_if.sv */
// Low-power mode activity and its exit pulse between detector and top.
`timescale 1ns/10ps
interface dsrp_lp_if;
    logic active;
    logic exit_pulse;
    modport det (input active, output exit_pulse);
    modport use_side (output active, input exit_pulse);
endinterface

/* include/dsrp_pkg.sv */
// Constants shared by the debug status and reset port.
package dsrp_pkg;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 4;
    // Register byte offsets.
    localparam logic [3:0] OFS_STATUS = 4'h0;
    localparam logic [3:0] OFS_CONTROL = 4'h4;
    localparam logic [3:0] OFS_INT_STAT = 4'h8;
    localparam logic [3:0] OFS_INT_MASK = 4'hc;
    // Status register bit positions.
    localparam int unsigned ST_SECURE = 2;
    localparam int unsigned ST_LLS_EXIT = 9;
    localparam int unsigned ST_VLLS_EXIT = 10;
    localparam int unsigned ST_HALTED = 16;
    localparam int unsigned ST_SLEEPDEEP = 17;
    localparam int unsigned ST_SLEEPING = 18;
    localparam logic [31:0] ST_RSVD_MASK = 32'hfff8_f800;
    // Control register bit positions.
    localparam int unsigned CT_ERASE = 0;
    localparam int unsigned CT_LP_ACK = 1;
    localparam int unsigned CT_SYS_RST = 3;
    localparam int unsigned CT_CORE_RST = 4;
    // Interrupt status and mask bit positions.
    localparam int unsigned IT_LLS = 0;
    localparam int unsigned IT_VLLS = 1;
    localparam int unsigned IT_HALT = 2;
    localparam int unsigned IT_W = 3;
    localparam logic [IT_W-1:0] IT_RESET = 3'h0;
endpackage

/* tb/dsrp_dbg_model.sv */
// Debugger link model: clocks the link while a debug reset is asked, and once more after it ends.
`timescale 1ns/10ps
module dsrp_dbg_model (
    input wire logic req_on,
    output logic link_clk,
    output logic rst_req
);
    initial begin
        link_clk = 1'b0;
        rst_req = 1'b0;
    end
    // The request is set up half a link period before each rising edge.
    // One more edge after the drop lets the device see the request end.
    always begin
        wait (req_on === 1'b1);
        rst_req <= 1'b1;
        while (req_on === 1'b1) begin
            #400 link_clk <= 1'b1;
            #400 link_clk <= 1'b0;
        end
        rst_req <= 1'b0;
        #400 link_clk <= 1'b1;
        #400 link_clk <= 1'b0;
    end
endmodule

/* tb/dsrp_top_bench.sv */
// Self-checking bench for the debug status and reset port.
`timescale 1ns/10ps
module dsrp_top_bench;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [dsrp_pkg::ADDR_W-1:0] addr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [dsrp_pkg::DATA_W-1:0] wdata = 32'h0;
    logic [dsrp_pkg::DATA_W-1:0] rdata, rdata_s;
    logic waitreq, wait_s, link_clk, rst_req;
    logic req_on = 1'b0;
    logic low_leakage_stop = 1'b0, vlls = 1'b0, halted = 1'b0, sdeep = 1'b0;
    logic sleeping = 1'b0, sys_req = 1'b0, secure = 1'b0;
    logic sys_rst_b, core_rst_b, dbg_rst_b, erase, irq;
    logic lf = 1'b0, vf = 1'b0;
    logic [31:0] seed = 32'h42f8d660;
    logic [31:0] exp_q[$];
    int errors = 0;
    int checks_done = 0;

    dsrp_top dut_u (.REF_CLK(ref_clk), .RST_B(rst_b), .AVS_ADDRESS(addr),
        .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
        .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq), .DBG_CLK(link_clk),
        .DBG_RST_REQ(rst_req), .LOW_LEAKAGE_STOP(low_leakage_stop),
        .VERY_LOW_LEAKAGE_STOP(vlls), .CORE_HALTED(halted),
        .CORE_SLEEPDEEP(sdeep), .CORE_SLEEPING(sleeping),
        .CORE_SYS_RESET_REQ(sys_req), .FLASH_SECURE(secure),
        .SYS_RESET_B(sys_rst_b), .CORE_RESET_B(core_rst_b),
        .DBG_LOGIC_RESET_B(dbg_rst_b), .MASS_ERASE_REQ(erase), .IRQ(irq));
    dsrp_dbg_model dbg_u (.req_on(req_on), .link_clk(link_clk),
        .rst_req(rst_req));

    always #50 ref_clk = ~ref_clk;

    task automatic stop_test();
        if (errors == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t read %h want %h", $time, got, exp);
        end
    endtask

    task automatic check_pin(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t pin %b want %b", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [31:0] st_exp();
        st_exp = {13'h0, sleeping, sdeep, halted, 5'h0, vf, lf, 6'h0,
            secure, 2'h0};
    endfunction

    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    task automatic bus(input logic w, input logic [3:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        rd <= ~w;
        wr <= w;
        addr <= a;
        wdata <= d;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wait_s !== 1'b0 && n < 200);
        rd <= 1'b0;
        wr <= 1'b0;
        if (n >= 200) begin
            errors++;
            stop_test();
        end
    endtask

    task automatic rd_reg(input logic [3:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic wait_dbg(input logic v);
        int n;
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (dbg_rst_b !== v && n < 100);
    endtask

    // Values standing just before each rising edge are what the edge sees.
    always @(negedge ref_clk) begin
        wait_s <= waitreq;
        rdata_s <= rdata;
    end

    always @(posedge ref_clk) begin
        if (rd === 1'b1 && wait_s === 1'b0) begin
            if (exp_q.size() > 0) begin
                check_word(rdata_s, exp_q.pop_front());
            end else begin
                errors++;
                $display("BAD %0t read with nothing expected", $time);
            end
        end
    end

    initial begin
        repeat (5000) @(posedge ref_clk);
        errors++;
        stop_test();
    end

    initial begin
        repeat (20) @(posedge ref_clk);
        rst_b <= 1'b1;
        settle(2);
        check_pin(sys_rst_b, 1'b1);
        check_pin(core_rst_b, 1'b1);
        check_pin(dbg_rst_b, 1'b1);
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            @(posedge ref_clk);
            {sleeping, sdeep, halted} <= i[2:0];
            wr_reg(dsrp_pkg::OFS_STATUS, seed);
            rd_reg(dsrp_pkg::OFS_STATUS, st_exp());
        end
        check_pin(irq, 1'b1);
        {sleeping, sdeep, halted} <= 3'h0;
        wr_reg(dsrp_pkg::OFS_INT_STAT, 32'h7);
        wr_reg(dsrp_pkg::OFS_CONTROL, 32'h1);
        low_leakage_stop <= 1'b1;
        fork
            rd_reg(dsrp_pkg::OFS_CONTROL, 32'h1);
            begin
                settle(12);
                check_pin(waitreq, 1'b1);
                check_pin(irq, 1'b0);
                @(posedge ref_clk);
                low_leakage_stop <= 1'b0;
            end
        join
        lf = 1'b1;
        settle(4);
        check_pin(erase, 1'b1);
        check_pin(irq, 1'b1);
        rd_reg(dsrp_pkg::OFS_STATUS, st_exp());
        rd_reg(dsrp_pkg::OFS_INT_STAT, 32'h1);
        wr_reg(dsrp_pkg::OFS_INT_MASK, 32'h7);
        settle(2);
        check_pin(irq, 1'b0);
        wr_reg(dsrp_pkg::OFS_CONTROL, 32'h3);
        lf = 1'b0;
        rd_reg(dsrp_pkg::OFS_STATUS, st_exp());
        vlls <= 1'b1;
        settle(4);
        check_pin(dbg_rst_b, 1'b0);
        @(posedge ref_clk);
        vlls <= 1'b0;
        vf = 1'b1;
        settle(6);
        check_pin(dbg_rst_b, 1'b1);
        check_pin(erase, 1'b0);
        check_pin(irq, 1'b1);
        rd_reg(dsrp_pkg::OFS_STATUS, st_exp());
        rd_reg(dsrp_pkg::OFS_CONTROL, 32'h0);
        wr_reg(dsrp_pkg::OFS_CONTROL, 32'h2);
        vf = 1'b0;
        rd_reg(dsrp_pkg::OFS_STATUS, st_exp());
        wr_reg(dsrp_pkg::OFS_INT_STAT, 32'h7);
        wr_reg(dsrp_pkg::OFS_CONTROL, 32'h8);
        settle(2);
        check_pin(irq, 1'b0);
        check_pin(sys_rst_b, 1'b0);
        check_pin(core_rst_b, 1'b1);
        wr_reg(dsrp_pkg::OFS_CONTROL, 32'h10);
        settle(2);
        check_pin(sys_rst_b, 1'b1);
        check_pin(core_rst_b, 1'b0);
        wr_reg(dsrp_pkg::OFS_CONTROL, 32'h0);
        sys_req <= 1'b1;
        settle(2);
        check_pin(sys_rst_b, 1'b0);
        @(posedge ref_clk);
        sys_req <= 1'b0;
        wr_reg(dsrp_pkg::OFS_CONTROL, 32'h1);
        req_on <= 1'b1;
        wait_dbg(1'b0);
        check_pin(dbg_rst_b, 1'b0);
        req_on <= 1'b0;
        wait_dbg(1'b1);
        settle(2);
        check_pin(erase, 1'b0);
        @(posedge ref_clk);
        secure <= 1'b1;
        settle(2);
        rd_reg(dsrp_pkg::OFS_STATUS, st_exp());
        wr_reg(dsrp_pkg::OFS_CONTROL, 32'h19);
        wr_reg(dsrp_pkg::OFS_INT_MASK, 32'h7);
        settle(2);
        check_pin(erase, 1'b1);
        check_pin(sys_rst_b, 1'b1);
        check_pin(core_rst_b, 1'b1);
        @(posedge ref_clk);
        secure <= 1'b0;
        settle(2);
        rd_reg(dsrp_pkg::OFS_INT_MASK, 32'h0);
        rd_reg(4'h6, 32'h0);
        settle(2);
        stop_test();
    end
endmodule

/* verilog/dsrp_lpexit.sv */
// Detects the end of a low-power mode and gives a one-cycle exit pulse.
`timescale 1ns/10ps
module dsrp_lpexit (
    input wire logic clk,
    input wire logic rst_b,
    dsrp_lp_if.det lp
);
    logic active_d_reg;
    logic exit_reg;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            active_d_reg <= 1'b0;
            exit_reg <= 1'b0;
        end else begin
            active_d_reg <= lp.active;
            exit_reg <= active_d_reg & ~lp.active;
        end
    end

    assign lp.exit_pulse = exit_reg;
endmodule

/* verilog/dsrp_sync.sv */
// Two-flop synchroniser for levels entering the reference clock domain.
`timescale 1ns/10ps
module dsrp_sync #(
    parameter int unsigned W = 1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule

/* verilog/dsrp_top.sv */
// Debug mailbox port status, debug resets and low-power handling.
`timescale 1ns/10ps
module dsrp_top (
    input wire logic REF_CLK,
    input wire logic RST_B,
    input wire logic [dsrp_pkg::ADDR_W-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [dsrp_pkg::DATA_W-1:0] AVS_WRITEDATA,
    output logic [dsrp_pkg::DATA_W-1:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic DBG_CLK,
    input wire logic DBG_RST_REQ,
    input wire logic LOW_LEAKAGE_STOP,
    input wire logic VERY_LOW_LEAKAGE_STOP,
    input wire logic CORE_HALTED,
    input wire logic CORE_SLEEPDEEP,
    input wire logic CORE_SLEEPING,
    input wire logic CORE_SYS_RESET_REQ,
    input wire logic FLASH_SECURE,
    output logic SYS_RESET_B,
    output logic CORE_RESET_B,
    output logic DBG_LOGIC_RESET_B,
    output logic MASS_ERASE_REQ,
    output logic IRQ
);
    logic [1:0] lnk_s;
    logic lnk_clk_d_reg;
    logic lnk_rise;
    logic dbg_req_reg;
    logic dbg_rst_b_reg;
    logic wait_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [31:0] status;
    logic pending;
    logic blocked;
    logic take;
    logic wr_ack;
    logic sel_stat;
    logic sel_ctl;
    logic sel_ist;
    logic sel_msk;
    logic lls_flag_reg;
    logic vlls_flag_reg;
    logic lp_ack;
    logic erase_reg;
    logic sysrst_reg;
    logic corerst_reg;
    logic sys_rst_b_reg;
    logic core_rst_b_reg;
    logic halt_d_reg;
    logic [dsrp_pkg::IT_W-1:0] ist_reg;
    logic [dsrp_pkg::IT_W-1:0] msk_reg;
    logic [dsrp_pkg::IT_W-1:0] ev;
    logic irq_reg;

    dsrp_lp_if lls_if();
    dsrp_lp_if vlls_if();

    assign lls_if.active = LOW_LEAKAGE_STOP;
    assign vlls_if.active = VERY_LOW_LEAKAGE_STOP;

    dsrp_lpexit u_lls (
        .clk(REF_CLK),
        .rst_b(RST_B),
        .lp(lls_if.det)
    );

    dsrp_lpexit u_vlls (
        .clk(REF_CLK),
        .rst_b(RST_B),
        .lp(vlls_if.det)
    );

    dsrp_sync #(.W(2)) u_sync (
        .clk(REF_CLK),
        .rst_b(RST_B),
        .d({DBG_CLK, DBG_RST_REQ}),
        .q(lnk_s)
    );

    // The debugger reset request is taken on rising edges of its clock.
    assign lnk_rise = lnk_s[1] & ~lnk_clk_d_reg;

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            lnk_clk_d_reg <= 1'b0;
            dbg_req_reg <= 1'b0;
        end else begin
            lnk_clk_d_reg <= lnk_s[1];
            if (lnk_rise) begin
                dbg_req_reg <= lnk_s[0];
            end
        end
    end

    // Debug logic reset: power-on, debugger request, or power loss.
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            dbg_rst_b_reg <= 1'b0;
        end else begin
            dbg_rst_b_reg <= ~(dbg_req_reg | VERY_LOW_LEAKAGE_STOP
                | vlls_if.exit_pulse);
        end
    end

    // Bus accesses stall while low leakage stop is active; very low leakage stop does not stall them.
    assign blocked = LOW_LEAKAGE_STOP;
    assign pending = AVS_READ | AVS_WRITE;
    assign take = pending & wait_reg & ~blocked;
    assign wr_ack = AVS_WRITE & ~wait_reg;
    assign sel_stat = AVS_ADDRESS == dsrp_pkg::OFS_STATUS;
    assign sel_ctl = AVS_ADDRESS == dsrp_pkg::OFS_CONTROL;
    assign sel_ist = AVS_ADDRESS == dsrp_pkg::OFS_INT_STAT;
    assign sel_msk = AVS_ADDRESS == dsrp_pkg::OFS_INT_MASK;

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            wait_reg <= 1'b1;
        end else begin
            wait_reg <= ~take;
        end
    end

    always_comb begin
        status = '0;
        status[dsrp_pkg::ST_SECURE] = FLASH_SECURE;
        status[dsrp_pkg::ST_LLS_EXIT] = lls_flag_reg;
        status[dsrp_pkg::ST_VLLS_EXIT] = vlls_flag_reg;
        status[dsrp_pkg::ST_HALTED] = CORE_HALTED;
        status[dsrp_pkg::ST_SLEEPDEEP] = CORE_SLEEPDEEP;
        status[dsrp_pkg::ST_SLEEPING] = CORE_SLEEPING;
    end

    always_comb begin
        rdata_next = '0;
        if (sel_stat) begin
            rdata_next = status;
        end else if (FLASH_SECURE) begin
            rdata_next = '0;
        end else if (sel_ctl) begin
            rdata_next[dsrp_pkg::CT_ERASE] = erase_reg;
            rdata_next[dsrp_pkg::CT_SYS_RST] = sysrst_reg;
            rdata_next[dsrp_pkg::CT_CORE_RST] = corerst_reg;
        end else if (sel_ist) begin
            rdata_next[dsrp_pkg::IT_W-1:0] = ist_reg;
        end else if (sel_msk) begin
            rdata_next[dsrp_pkg::IT_W-1:0] = msk_reg;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            rdata_reg <= '0;
        end else if (take && AVS_READ) begin
            rdata_reg <= rdata_next;
        end
    end

    // Acknowledge of the exit flags; honoured even when secured.
    assign lp_ack = wr_ack & sel_ctl & AVS_WRITEDATA[dsrp_pkg::CT_LP_ACK];

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            lls_flag_reg <= 1'b0;
        end else if (lls_if.exit_pulse) begin
            lls_flag_reg <= 1'b1;
        end else if (lp_ack) begin
            lls_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            vlls_flag_reg <= 1'b0;
        end else if (vlls_if.exit_pulse) begin
            vlls_flag_reg <= 1'b1;
        end else if (lp_ack) begin
            vlls_flag_reg <= 1'b0;
        end
    end

    // Control bits; a status write matches no branch and is dropped.
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            erase_reg <= 1'b0;
            sysrst_reg <= 1'b0;
            corerst_reg <= 1'b0;
        end else if (!dbg_rst_b_reg) begin
            erase_reg <= 1'b0;
            sysrst_reg <= 1'b0;
            corerst_reg <= 1'b0;
        end else if (wr_ack && sel_ctl) begin
            erase_reg <= AVS_WRITEDATA[dsrp_pkg::CT_ERASE];
            if (!FLASH_SECURE) begin
                sysrst_reg <= AVS_WRITEDATA[dsrp_pkg::CT_SYS_RST];
                corerst_reg <= AVS_WRITEDATA[dsrp_pkg::CT_CORE_RST];
            end
        end else if (FLASH_SECURE) begin
            sysrst_reg <= 1'b0;
            corerst_reg <= 1'b0;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            sys_rst_b_reg <= 1'b1;
            core_rst_b_reg <= 1'b1;
        end else begin
            sys_rst_b_reg <= ~(sysrst_reg | CORE_SYS_RESET_REQ);
            core_rst_b_reg <= ~corerst_reg;
        end
    end

    // Interrupt status: sticky, write one to clear, set wins over clear.
    assign ev[dsrp_pkg::IT_LLS] = lls_if.exit_pulse;
    assign ev[dsrp_pkg::IT_VLLS] = vlls_if.exit_pulse;
    assign ev[dsrp_pkg::IT_HALT] = CORE_HALTED & ~halt_d_reg;

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            halt_d_reg <= 1'b0;
            ist_reg <= dsrp_pkg::IT_RESET;
        end else begin
            halt_d_reg <= CORE_HALTED;
            if (wr_ack && sel_ist && !FLASH_SECURE) begin
                ist_reg <= ev
                    | (ist_reg & ~AVS_WRITEDATA[dsrp_pkg::IT_W-1:0]);
            end else begin
                ist_reg <= ist_reg | ev;
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            msk_reg <= dsrp_pkg::IT_RESET;
        end else if (!dbg_rst_b_reg) begin
            msk_reg <= dsrp_pkg::IT_RESET;
        end else if (wr_ack && sel_msk && !FLASH_SECURE) begin
            msk_reg <= AVS_WRITEDATA[dsrp_pkg::IT_W-1:0];
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            irq_reg <= 1'b0;
        end else begin
            // A set mask bit keeps its status bit off the interrupt line.
            irq_reg <= |(ist_reg & ~msk_reg);
        end
    end

    assign AVS_READDATA = rdata_reg;
    assign AVS_WAITREQUEST = wait_reg;
    assign SYS_RESET_B = sys_rst_b_reg;
    assign CORE_RESET_B = core_rst_b_reg;
    assign DBG_LOGIC_RESET_B = dbg_rst_b_reg;
    assign MASS_ERASE_REQ = erase_reg;
    assign IRQ = irq_reg;

    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RST_B);

    sequence s_req;
        pending && wait_reg && !blocked;
    endsequence

    sequence s_ack;
        !wait_reg ##1 wait_reg;
    endsequence

    a_lls_exit_set: assert property (
        lls_if.exit_pulse |=> lls_flag_reg)
        else $error("low leakage exit flag not set");

    a_lp_ack_clear: assert property (
        lp_ack && !lls_if.exit_pulse && !vlls_if.exit_pulse
        |=> !lls_flag_reg && !vlls_flag_reg)
        else $error("exit flags not cleared by acknowledge");

    a_vlls_flag_hold: assert property (
        vlls_flag_reg && !lp_ack |=> vlls_flag_reg)
        else $error("very low leakage exit flag lost");

    a_rsvd_zero: assert property (
        (AVS_READDATA & dsrp_pkg::ST_RSVD_MASK) == '0)
        else $error("reserved status bits not zero");

    a_bus_answer: assert property (
        s_req |=> s_ack)
        else $error("bus answer not one cycle after request");

    a_lls_block: assert property (
        LOW_LEAKAGE_STOP |=> AVS_WAITREQUEST)
        else $error("bus answered during low leakage stop");

    a_sys_hold: assert property (
        sysrst_reg |=> !SYS_RESET_B)
        else $error("system not held in reset");

    a_dbg_reset: assert property (
        $rose(dbg_req_reg) |=> !DBG_LOGIC_RESET_B ##1 !sysrst_reg)
        else $error("debug reset did not clear control");

    a_vlls_reset: assert property (
        vlls_if.exit_pulse |=> !DBG_LOGIC_RESET_B)
        else $error("debug logic not reset after recovery");

    a_secure_deny: assert property (
        FLASH_SECURE |=> ##1 CORE_RESET_B)
        else $error("core reset allowed while secured");

    a_vlls_exit_set: assert property (
        vlls_if.exit_pulse |=> vlls_flag_reg)
        else $error("very low leakage exit flag not set");

    a_sw_sys_reset: assert property (
        CORE_SYS_RESET_REQ |=> !SYS_RESET_B)
        else $error("software reset request gave no system reset");

    a_core_hold: assert property (
        corerst_reg |=> !CORE_RESET_B)
        else $error("core not held in reset");

    a_lls_keep_state: assert property (
        LOW_LEAKAGE_STOP && DBG_LOGIC_RESET_B && !wr_ack
        |=> $stable(MASS_ERASE_REQ))
        else $error("debug state changed during low leakage stop");
endmodule
